//--- eoc_pkg.sv
/*
  eoc_pkg: constants for the operations-channel identity and
  configuration query responder.
  assumes: byte-serial command and response streams, one clock.
*/
// Overview of operation
// - identity reply: opcode, then fields 1,4,8,20,20,1,4,4,4,2 bytes in order
// - application kind byte is 0x00 downloadable or 0x01 rom-only; never reserved
// - active interface map is two bytes, one set bit per active interface
// - interface identity query opcode 0x13, answered with 0x93
// - identity reply returns interface type, software version and hardware code
// - selector one-hot: 0x0000 none, 0x0001..0x0008 first to fourth interface of the requested type
// - type codes 0x00,0x01,0x02,0x04,0x08; upper nibble values reserved
// - config query treats enhanced atm 25.6 (0x04) as default type
// - interface software version is four ascii bytes
// - interface config query opcode 0x14, answered with 0x94
// - config reply layout chosen from the selected interface type
// - bridge config reply echoes selector and type before state byte
// - response opcode equals command opcode with msb set; a refused query gets 0xFF instead
// - state bit 0 disabled/enabled, bit 1 learning/static bridge
package eoc_pkg;
  localparam logic [7:0]  EOC_OP_UNIT_ID   = 8'h12;
  localparam logic [7:0]  EOC_OP_IF_ID     = 8'h13;
  localparam logic [7:0]  EOC_OP_IF_CFG    = 8'h14;
  localparam logic [7:0]  EOC_RSP_FLAG     = 8'h80;
  localparam logic [7:0]  EOC_APP_DOWNLOAD = 8'h00;
  localparam logic [7:0]  EOC_APP_ROM      = 8'h01;
  localparam logic [7:0]  EOC_TYPE_NONE    = 8'h00;
  localparam logic [7:0]  EOC_TYPE_ATM     = 8'h01;
  localparam logic [7:0]  EOC_TYPE_BRIDGE  = 8'h02;
  localparam logic [7:0]  EOC_TYPE_ATM_ENH = 8'h04;
  localparam logic [7:0]  EOC_TYPE_ROUTED  = 8'h08;
  localparam logic [15:0] EOC_SEL_NONE     = 16'h0000;
  localparam int          EOC_NUM_IF       = 4;
  // identity record length after opcode: 1+4+8+20+20+1+4+4+4+2
  localparam int          EOC_UNIT_ID_LEN  = 68;
  localparam int          EOC_IF_ID_LEN    = 3 + 4 + 4;
  localparam int          EOC_CFG_BR_LEN   = 4;
  localparam int          EOC_CFG_GEN_LEN  = 3;
  localparam logic [7:0]  EOC_INVALID_OP   = 8'hFF;
  localparam int          EOC_ROM_BYTES    = 128;
  typedef enum logic [2:0] {
    EOC_IDLE, EOC_SEL_HI, EOC_SEL_LO, EOC_TYPE, EOC_SEND
  } eoc_state_e;
endpackage

//--- eoc_id_rom.sv
/*
  eoc_id_rom: identity byte store, registered read data.
  assumes: contents loaded by the unit's firmware over the write port.
*/
`timescale 1ns/1ps
`default_nettype none
module eoc_id_rom #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // clock
  input  wire logic          core_clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];
  // no reset on storage; contents are written before queries arrive
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

//--- eoc_responder.sv
/*
  eoc_responder: decodes identity and configuration queries and streams
  byte-serial responses.
  assumes: command bytes arrive framed by cmd_first with cmd_valid;
  rom holds: 0..67 unit identity record, 68+4*i per-interface sw version,
  84+4*i per-interface hw code.
*/
`timescale 1ns/1ps
`default_nettype none
module eoc_responder
  import eoc_pkg::*;
#(
  parameter int AW = 7
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // command stream
  input  wire logic          cmd_valid,
  input  wire logic          cmd_first,
  input  wire logic [7:0]    cmd_data,
  // response stream
  output logic               rsp_valid,
  output logic               rsp_last,
  output logic [7:0]         rsp_data,
  input  wire logic          rsp_ready,
  // status
  output logic               query_invalid,
  // unit configuration
  input  wire logic [7:0]    application_kind,
  input  wire logic [15:0]   active_if_map,
  input  wire logic [31:0]   if_type_list,
  input  wire logic [7:0]    if_enable_map,
  // identity store loading
  input  wire logic          id_wr_en,
  input  wire logic [AW-1:0] id_wr_addr,
  input  wire logic [7:0]    id_wr_data
);
  import eoc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    eoc_state_e  st;
    logic [7:0]  op;
    logic [15:0] sel;
    logic [7:0]  typ;
    logic [6:0]  idx;
    logic [6:0]  len;
    logic        bad;
    logic        vld;
    logic        prime;
    logic [7:0]  dat;
  } eoc_regs_s;

  eoc_regs_s r_q, r_d;
  logic [7:0]    rom_q;
  logic [AW-1:0] rom_a;
  logic [1:0]    if_num;
  logic          sel_ok;
  logic [7:0]    sel_type;
  logic [7:0]    req_type;
  logic [2:0]    rank;
  logic [7:0]    nxt;

  eoc_id_rom #(.DEPTH(EOC_ROM_BYTES), .AW(AW)) u_rom (
    .core_clk (core_clk),
    .wr_en    (id_wr_en),
    .wr_addr  (id_wr_addr),
    .wr_data  (id_wr_data),
    .rd_addr  (rom_a),
    .rd_data  (rom_q)
  );

  // ----------------------------------------
  // selector and type decode
  // ----------------------------------------
  // selector counts interfaces of the requested type, not all interfaces
  always_comb begin
    req_type = (r_q.st == EOC_TYPE) ? cmd_data : r_q.typ;
    if (req_type == EOC_TYPE_NONE) begin
      req_type = EOC_TYPE_ATM_ENH;
    end
    sel_ok = 1'b0;
    if_num = 2'd0;
    rank   = 3'd0;
    for (int i = 0; i < EOC_NUM_IF; i++) begin
      if (if_type_list[8*i +: 8] == req_type) begin
        if (r_q.sel == (16'h0001 << rank)) begin
          sel_ok = 1'b1;
          if_num = 2'(i);
        end
        rank = rank + 3'd1;
      end
    end
    sel_type = if_type_list[8*if_num +: 8];
  end

  // ----------------------------------------
  // byte builder
  // ----------------------------------------
  always_comb begin
    rom_a = '0;
    nxt   = 8'h00;
    if (r_q.idx == 7'd0) begin
      nxt = r_q.bad ? EOC_INVALID_OP : (r_q.op | EOC_RSP_FLAG);
    end else if (r_q.op == EOC_OP_UNIT_ID) begin
      rom_a = AW'(r_q.idx - 7'd1);
      if (r_q.idx == 7'd1) begin
        // reserved kinds are coerced to rom-only, never sent
        nxt = (application_kind == EOC_APP_DOWNLOAD) ? EOC_APP_DOWNLOAD : EOC_APP_ROM;
      end else if (r_q.idx == 7'(EOC_UNIT_ID_LEN - 1)) begin
        nxt = active_if_map[15:8];
      end else if (r_q.idx == 7'(EOC_UNIT_ID_LEN)) begin
        nxt = active_if_map[7:0];
      end else begin
        nxt = rom_q;
      end
    end else begin
      case (r_q.idx)
        7'd1:    nxt = r_q.sel[15:8];
        7'd2:    nxt = r_q.sel[7:0];
        7'd3:    nxt = sel_type;
        default: begin
          if (r_q.op == EOC_OP_IF_ID) begin
            // sw version ascii then hw code, four bytes each
            rom_a = AW'(EOC_UNIT_ID_LEN + 7'(4 * if_num) + r_q.idx - 7'd4);
            if (r_q.idx >= 7'd8) begin
              rom_a = AW'(EOC_UNIT_ID_LEN + 16 + 7'(4 * if_num) + r_q.idx - 7'd8);
            end
            nxt = rom_q;
          end else begin
            nxt = {6'h00, 1'b0, if_enable_map[if_num]};
            if (sel_type == EOC_TYPE_BRIDGE) begin
              nxt[1] = if_enable_map[4 + if_num];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // command decode and send sequencing
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    if (r_q.vld && rsp_ready) begin
      r_d.vld = 1'b0;
    end
    case (r_q.st)
      EOC_IDLE: begin
        if (cmd_valid && cmd_first) begin
          r_d.op  = cmd_data;
          r_d.sel = EOC_SEL_NONE;
          r_d.typ = EOC_TYPE_ATM_ENH;
          r_d.idx = '0;
          r_d.bad = 1'b0;
          if (cmd_data == EOC_OP_UNIT_ID) begin
            r_d.len = 7'(EOC_UNIT_ID_LEN);
            r_d.st  = EOC_SEND;
          end else if (cmd_data == EOC_OP_IF_ID || cmd_data == EOC_OP_IF_CFG) begin
            r_d.st = EOC_SEL_HI;
          end
        end
      end
      EOC_SEL_HI: begin
        if (cmd_valid) begin
          r_d.sel[15:8] = cmd_data;
          r_d.st        = EOC_SEL_LO;
        end
      end
      EOC_SEL_LO: begin
        if (cmd_valid) begin
          r_d.sel[7:0] = cmd_data;
          r_d.st       = EOC_TYPE;
        end
      end
      EOC_TYPE: begin
        if (cmd_valid) begin
          // an unused type field falls back to the default type
          r_d.typ = (cmd_data == EOC_TYPE_NONE) ? EOC_TYPE_ATM_ENH : cmd_data;
          // no k-th interface of that type is refused like a bad selector
          r_d.bad = !sel_ok || (cmd_data[7:4] != 4'h0);
          r_d.st  = EOC_SEND;
          if (r_q.op == EOC_OP_IF_ID) begin
            r_d.len = 7'(EOC_IF_ID_LEN);
          end else if (sel_type == EOC_TYPE_BRIDGE) begin
            r_d.len = 7'(EOC_CFG_BR_LEN);
          end else begin
            r_d.len = 7'(EOC_CFG_GEN_LEN);
          end
        end
      end
      EOC_SEND: begin
        // two-step: address the store, then capture the byte
        if (!r_q.vld || rsp_ready) begin
          if (!r_q.prime) begin
            r_d.prime = 1'b1;
            r_d.vld   = 1'b0;
          end else begin
            r_d.prime = 1'b0;
            r_d.vld   = 1'b1;
            r_d.dat   = nxt;
            r_d.idx   = r_q.idx + 7'd1;
            if (r_q.idx == r_q.len || r_q.bad) begin
              r_d.st = EOC_IDLE;
            end
          end
        end
      end
      default: r_d.st = EOC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '{st: EOC_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign rsp_valid     = r_q.vld;
  assign rsp_data      = r_q.dat;
  assign rsp_last      = r_q.vld && (r_q.st == EOC_IDLE);
  assign query_invalid = r_q.bad;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  rsp_flag_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.vld && r_q.idx == 7'd1 && !r_q.bad) |-> rsp_data[7])
    else $error("response opcode lacks flag");
  app_kind_ok_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.vld && r_q.op == EOC_OP_UNIT_ID && r_q.idx == 7'd2) |-> rsp_data <= EOC_APP_ROM)
    else $error("reserved application kind sent");
  bad_short_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.vld && r_q.bad) |-> rsp_last && rsp_data == EOC_INVALID_OP)
    else $error("invalid query returned data");
  if_id_op_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.vld && r_q.idx == 7'd1 && !r_q.bad && r_q.op == EOC_OP_IF_ID) |-> rsp_data == 8'h93)
    else $error("wrong identity opcode");
  cfg_op_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.vld && r_q.idx == 7'd1 && !r_q.bad && r_q.op == EOC_OP_IF_CFG) |-> rsp_data == 8'h94)
    else $error("wrong config opcode");
  sel_onehot_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.st == EOC_SEND && !r_q.bad && r_q.op != EOC_OP_UNIT_ID) |-> $onehot(r_q.sel[3:0])
    && r_q.sel[15:4] == 12'h000)
    else $error("data for bad selector");
  unit_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rsp_last && r_q.op == EOC_OP_UNIT_ID && !r_q.bad) |-> r_q.idx == 7'(EOC_UNIT_ID_LEN + 1))
    else $error("identity record length wrong");
  hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rsp_valid && !rsp_ready) |=> rsp_valid && $stable(rsp_data))
    else $error("response byte dropped");
  cfg_state_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rsp_last && r_q.op == EOC_OP_IF_CFG && !r_q.bad && sel_type == EOC_TYPE_BRIDGE)
    |-> rsp_data[7:2] == 6'h00)
    else $error("state reserved bits set");
  type_match_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_q.st == EOC_SEND && !r_q.bad && r_q.op != EOC_OP_UNIT_ID) |-> sel_type == r_q.typ)
    else $error("reply type differs from requested type");
  unit_c: cover property (@(posedge core_clk) rsp_last && r_q.op == EOC_OP_UNIT_ID);
  ifid_c: cover property (@(posedge core_clk) rsp_last && r_q.op == EOC_OP_IF_ID);
  cfg_c:  cover property (@(posedge core_clk) rsp_last && r_q.op == EOC_OP_IF_CFG);
  bad_c:  cover property (@(posedge core_clk) rsp_last && r_q.bad);
endmodule
`default_nettype wire

//--- eoc_co_model.sv
/*
  eoc_co_model: central-office side, takes response bytes.
  assumes: bench pulses clr before each query.
*/
`timescale 1ns/1ps
`default_nettype none
module eoc_co_model (
  // clock, reset, bench control
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clr,
  input  wire logic       slow,
  // response stream
  input  wire logic       rsp_valid,
  input  wire logic       rsp_last,
  input  wire logic [7:0] rsp_data,
  output logic            rsp_ready
);
  logic [7:0] got [0:127];
  int         n;
  logic       done;
  logic       can_dl;
  // slow mode stalls every other cycle, so held bytes get tested
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_ready <= 1'b0;
      n         <= 0;
      done      <= 1'b0;
      can_dl    <= 1'b0;
    end else begin
      rsp_ready <= slow ? !rsp_ready : 1'b1;
      if (clr) begin
        n    <= 0;
        done <= 1'b0;
      end else if (rsp_valid && rsp_ready) begin
        got[n] <= rsp_data;
        n      <= n + 1;
        done   <= rsp_last;
        if (n == 1 && got[0] === 8'h92) begin
          can_dl <= (rsp_data === 8'h00);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  tb_top: query sequences against the responder.
  assumes: eoc_co_model takes the response bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eoc_pkg::*;
  logic        core_clk, arst_n, cmd_valid, cmd_first, clr, slow;
  logic        rsp_valid, rsp_last, rsp_ready, query_invalid, id_wr_en;
  logic [7:0]  cmd_data, rsp_data, application_kind, if_enable_map, id_wr_data, ty;
  logic [15:0] active_if_map, sel;
  logic [31:0] if_type_list;
  logic [6:0]  id_wr_addr;
  logic [7:0]  exp_q [$];
  logic [23:0] bad [5];
  int          fails, num_checks;
  eoc_responder i_dut (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_first(cmd_first), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .query_invalid(query_invalid), .application_kind(application_kind),
    .active_if_map(active_if_map), .if_type_list(if_type_list),
    .if_enable_map(if_enable_map), .id_wr_en(id_wr_en), .id_wr_addr(id_wr_addr),
    .id_wr_data(id_wr_data));
  eoc_co_model i_co (.core_clk(core_clk), .arst_n(arst_n), .clr(clr), .slow(slow),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] sb(input int a);
    return 8'(a + 32);
  endfunction
  // selector counts interfaces of one type, so a lone one is 0x0001
  function automatic logic [15:0] rank_sel(input int i);
    int r;
    r = 0;
    for (int j = 0; j < i; j++) begin
      if (if_type_list[8*j+:8] == if_type_list[8*i+:8]) r++;
    end
    return 16'(1 << r);
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // short frame for unit identity, four bytes otherwise
  task automatic query(input logic [7:0] op, input logic [15:0] s, input logic [7:0] t);
    int k;
    @(negedge core_clk) clr = 1'b1;
    @(negedge core_clk) clr = 1'b0;
    cmd_valid = 1'b1;
    cmd_first = 1'b1;
    cmd_data  = op;
    if (op != EOC_OP_UNIT_ID) begin
      @(negedge core_clk) cmd_first = 1'b0;
      cmd_data = s[15:8];
      @(negedge core_clk) cmd_data = s[7:0];
      @(negedge core_clk) cmd_data = t;
    end
    @(negedge core_clk) cmd_valid = 1'b0;
    cmd_first = 1'b0;
    k = 0;
    while (i_co.done !== 1'b1 && k < 400) begin
      @(negedge core_clk) k++;
    end
    if (i_co.done !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic cmp_rsp(input string what);
    chk({what, " len"}, 8'(exp_q.size()), 8'(i_co.n));
    foreach (exp_q[k]) chk(what, exp_q[k], i_co.got[k]);
    exp_q.delete();
  endtask
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = !core_clk;
  end
  initial begin
    {arst_n, cmd_valid, cmd_first, clr, slow, id_wr_en} = '0;
    {cmd_data, id_wr_data, id_wr_addr, application_kind} = '0;
    active_if_map = 16'hA05C;
    if_type_list  = 32'h0204_0102;
    if_enable_map = 8'h1D;
    bad = '{24'h0003_02, 24'h0000_02, 24'h0010_02, 24'h0001_12, 24'h0002_01};
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    for (int a = 0; a < 128; a++) begin
      @(negedge core_clk) id_wr_en = 1'b1;
      id_wr_addr = 7'(a);
      id_wr_data = sb(a);
    end
    @(negedge core_clk) id_wr_en = 1'b0;
    for (int m = 0; m < 2; m++) begin
      slow = 1'(m);
      application_kind = m ? 8'h07 : 8'h00;
      query(EOC_OP_UNIT_ID, 16'h0000, 8'h00);
      exp_q = '{8'h92, 8'(m)};
      for (int a = 1; a < 66; a++) exp_q.push_back(sb(a));
      exp_q.push_back(8'hA0);
      exp_q.push_back(8'h5C);
      cmp_rsp("unit id");
      chk("can download", m ? 8'h00 : 8'h01, {7'h00, i_co.can_dl});
    end
    slow = 1'b0;
    foreach (bad[b]) begin
      query(EOC_OP_IF_ID, bad[b][23:8], bad[b][7:0]);
      exp_q = '{8'hFF};
      cmp_rsp("bad query");
      chk("invalid flag", 8'h01, {7'h00, query_invalid});
    end
    for (int i = 0; i < 4; i++) begin
      sel = rank_sel(i);
      ty  = if_type_list[8*i+:8];
      query(EOC_OP_IF_ID, sel, ty);
      chk("invalid flag", 8'h00, {7'h00, query_invalid});
      exp_q = '{8'h93, sel[15:8], sel[7:0], ty};
      for (int j = 0; j < 4; j++) exp_q.push_back(sb(68 + 4*i + j));
      for (int j = 0; j < 4; j++) exp_q.push_back(sb(84 + 4*i + j));
      cmp_rsp("if id");
    end
    for (int i = 0; i < 5; i++) begin
      sel = rank_sel(i % 4);
      ty  = if_type_list[8*(i%4)+:8];
      if (i == 4) begin
        @(negedge core_clk) if_enable_map = 8'h00;
      end
      query(EOC_OP_IF_CFG, sel, (i == 2) ? 8'h00 : ty);
      exp_q = '{8'h94, sel[15:8], sel[7:0], ty};
      if (ty == EOC_TYPE_BRIDGE) exp_q.push_back((i == 0) ? 8'h03 : (i == 3) ? 8'h01 : 8'h00);
      cmp_rsp("if cfg");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
